/* File: rtl/lcd_drv_defs.vh */
`ifndef LCD_DRV_DEFS_VH
`define LCD_DRV_DEFS_VH

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define FRAME_BITS      88
`define SEG_COUNT       80
`define ROW_COUNT       5
`define SEG_TOP         87
`define SEL_TOP         7
`define SEL_BOT         3

// ----------------------------------------------------------------------------
// Output drive levels
// ----------------------------------------------------------------------------
`define LVL_LOW         2'h0
`define LVL_MID1        2'h1
`define LVL_MID2        2'h2
`define LVL_HIGH        2'h3

// ----------------------------------------------------------------------------
// Duty phase counts
// ----------------------------------------------------------------------------
`define PHASES_3        3'h3
`define PHASES_4        3'h4
`define PHASES_5        3'h5

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define REF_RATE_HZ     10000000
`define OSC_RATE_HZ     8000
`define OSC_DIV_CYC     (`REF_RATE_HZ / `OSC_RATE_HZ)
`define PHASE_TICKS     5'h10
`define HALF_TICKS      5'h08
`define FIFO_DEPTH      16

`endif

/* File: rtl/lcd_segment_driver.v */
// How it works
// - Serial data is sampled on each rising shift clock edge.
// - An 88-stage shift register collects one whole frame.
// - A rising strobe edge queues segment bits, copied into selected row latches on an oscillator tick.
// - Segment bit one drives the segment on, zero drives it off.
// - Blank low forces every segment off without touching the latches.
// - Duty pins pick 1/3, 1/4 or 1/5; high upper pin means 1/5.
// - Each select bit enables one row latch, first bit for first common.
// - Several set select bits write the same segment bits to each latch.
// - Dummy bits of the frame are ignored entirely.
// - Common scanning runs from the internal divider or the external clock, not the shift clock.
// - Eighty segment outputs follow the latch of the active common phase.
`include "lcd_drv_defs.vh"

// ----------------------------------------------------------------------------
// Latch word FIFO
// ----------------------------------------------------------------------------
module lcd_word_fifo #(
    parameter WIDTH = 85,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             ref_clk_in,
    input  wire             rst_in,
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_r;
    reg [AW-1:0]    rd_ptr_r;
    reg [AW:0]      count_r;
    wire            push;
    wire            pop;

    // Full and empty come straight from the word count.
    assign in_ready_out  = (count_r != DEPTH[AW:0]);
    assign out_valid_out = (count_r != {(AW+1){1'b0}});
    assign out_data_out  = mem_r[rd_ptr_r];
    assign push = in_valid_in & in_ready_out;
    assign pop  = out_valid_out & out_ready_in;

    // Storage array has no reset.
    always @(posedge ref_clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end

    // Pointers wrap at the depth, which must be a power of two.
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push & ~pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop & ~push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

// ----------------------------------------------------------------------------
// Segment driver top
// ----------------------------------------------------------------------------
module lcd_segment_driver #(
    parameter OSC_DIV = `OSC_DIV_CYC
) (
    input  wire         ref_clk_in,
    input  wire         rst_in,
    input  wire         ser_data_in,
    input  wire         shift_clk_in,
    input  wire         strobe_in,
    input  wire         blank_n_in,
    input  wire         duty_sel_lo_in,
    input  wire         duty_sel_hi_in,
    input  wire         ext_osc_sel_in,
    input  wire         rc_a_in,
    output reg          load_ready_out,
    output reg  [9:0]   common_out,
    output reg  [159:0] segment_out
);
    localparam WW = `SEG_COUNT + `ROW_COUNT;

    // Synchroniser chains: stage one is read only by stage two.
    reg [7:0]  sync1_r;
    reg [7:0]  sync2_r;
    reg        sclk_prev_r;
    reg        strobe_prev_r;
    reg        rca_prev_r;
    wire       data_s   = sync2_r[0];
    wire       sclk_s   = sync2_r[1];
    wire       strobe_s = sync2_r[2];
    wire       blank_n_s = sync2_r[3];
    wire       rca_s    = sync2_r[4];
    wire       ext_s    = sync2_r[5];
    wire       duty_lo_s = sync2_r[6];
    wire       duty_hi_s = sync2_r[7];

    reg [`FRAME_BITS-1:0] shift_r;
    reg [WW-1:0]          word;
    integer               i;

    wire          fifo_in_ready;
    wire          fifo_out_valid;
    wire [WW-1:0] fifo_out_data;
    wire          osc_tick;

    reg [`SEG_COUNT-1:0] row_latch [0:`ROW_COUNT-1];
    reg [11:0]  div_r;
    reg [2:0]   phase_r;
    reg [4:0]   tick_r;
    reg [2:0]   phases;
    reg [9:0]   com_nxt;
    reg [159:0] seg_nxt;
    reg         half2;
    reg         on_bit;
    integer     k;
    integer     j;

    // Pick a level by polarity half: first half, second half.
    function [1:0] lvl;
        input h2;
        input [1:0] a;
        input [1:0] b;
        begin
            lvl = h2 ? b : a;
        end
    endfunction

    // Two-flop capture of every pin from outside the clock domain.
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_r       <= 8'h00;
            sync2_r       <= 8'h00;
            sclk_prev_r   <= 1'b0;
            strobe_prev_r <= 1'b0;
            rca_prev_r    <= 1'b0;
        end else begin
            sync1_r <= {duty_sel_hi_in, duty_sel_lo_in,
                        ext_osc_sel_in, rc_a_in, blank_n_in,
                        strobe_in, shift_clk_in, ser_data_in};
            sync2_r       <= sync1_r;
            sclk_prev_r   <= sclk_s;
            strobe_prev_r <= strobe_s;
            rca_prev_r    <= rca_s;
        end
    end

    // Shift register takes one bit per rising shift clock edge.
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            shift_r <= {`FRAME_BITS{1'b0}};
        end else if (sclk_s & ~sclk_prev_r) begin
            shift_r <= {shift_r[`FRAME_BITS-2:0], data_s};
        end
    end

    // First bit shifted sits at the top; segment n is reversed to bit n.
    always @* begin
        word = {WW{1'b0}};
        for (i = 0; i < `SEG_COUNT; i = i + 1) begin
            word[i] = shift_r[`SEG_TOP - i];
        end
        for (i = 0; i < `ROW_COUNT; i = i + 1) begin
            word[`SEG_COUNT + i] = shift_r[`SEL_TOP - i];
        end
        // Bits below the select field are dummies and never read.
    end

    // A strobe rising edge queues one latch word; full drops it.
    lcd_word_fifo #(
        .WIDTH (WW),
        .DEPTH (`FIFO_DEPTH),
        .AW    (4)
    ) u_fifo (
        .ref_clk_in    (ref_clk_in),
        .rst_in        (rst_in),
        .in_valid_in   (strobe_s & ~strobe_prev_r),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (word),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (osc_tick),
        .out_data_out  (fifo_out_data)
    );

    // Latches change only on a drained word, once per oscillator tick.
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (j = 0; j < `ROW_COUNT; j = j + 1) begin
                row_latch[j] <= {`SEG_COUNT{1'b0}};
            end
        end else if (fifo_out_valid & osc_tick) begin
            for (j = 0; j < `ROW_COUNT; j = j + 1) begin
                if (fifo_out_data[`SEG_COUNT + j]) begin
                    row_latch[j] <= fifo_out_data[`SEG_COUNT-1:0];
                end
            end
        end
    end

    // Oscillator tick: internal divider or rising edges of the external clock.
    assign osc_tick = ext_s ? (rca_s & ~rca_prev_r)
                            : (div_r == 12'h000);

    // Divider and scan counters, free of the shift clock.
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_r   <= 12'h000;
            phase_r <= 3'h0;
            tick_r  <= 5'h00;
        end else begin
            if (div_r == 12'h000) begin
                div_r <= OSC_DIV[11:0] - 12'h001;
            end else begin
                div_r <= div_r - 12'h001;
            end
            if (osc_tick) begin
                if (tick_r == `PHASE_TICKS - 5'h01) begin
                    tick_r <= 5'h00;
                    if (phase_r >= phases - 3'h1) begin
                        phase_r <= 3'h0;
                    end else begin
                        phase_r <= phase_r + 3'h1;
                    end
                end else begin
                    tick_r <= tick_r + 5'h01;
                end
            end
        end
    end

    // Duty decode and output level selection.
    always @* begin
        on_bit = 1'b0;
        if (duty_hi_s) begin
            phases = `PHASES_5;
        end else if (duty_lo_s) begin
            phases = `PHASES_4;
        end else begin
            phases = `PHASES_3;
        end
        half2   = (tick_r >= `HALF_TICKS);
        com_nxt = 10'h000;
        seg_nxt = 160'h0;
        for (k = 0; k < `ROW_COUNT; k = k + 1) begin
            if (k == phase_r) begin
                com_nxt[2*k +: 2] = lvl(half2, `LVL_HIGH, `LVL_LOW);
            end else begin
                com_nxt[2*k +: 2] = lvl(half2, `LVL_MID2, `LVL_MID1);
            end
        end
        for (k = 0; k < `SEG_COUNT; k = k + 1) begin
            on_bit = row_latch[phase_r][k] & blank_n_s;
            if (on_bit) begin
                seg_nxt[2*k +: 2] = lvl(half2, `LVL_LOW, `LVL_HIGH);
            end else begin
                seg_nxt[2*k +: 2] = lvl(half2, `LVL_MID1, `LVL_MID2);
            end
        end
    end

    // Registered outputs.
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            common_out     <= 10'h000;
            segment_out    <= 160'h0;
            load_ready_out <= 1'b0;
        end else begin
            common_out     <= com_nxt;
            segment_out    <= seg_nxt;
            load_ready_out <= fifo_in_ready;
        end
    end
endmodule

/* File: tb/lcd_segment_driver_chk.sv */
// ---------------------------------------------------------------
// Scan and blank checker
// ---------------------------------------------------------------
module lcd_drv_chk #(
    parameter OSC_DIV = 4
) (
    input wire         ref_clk_in,
    input wire         rst_in,
    input wire         blank_n_in,
    input wire         duty_sel_lo_in,
    input wire         duty_sel_hi_in,
    input wire         ext_osc_sel_in,
    input wire [9:0]   common_out,
    input wire [159:0] segment_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0]  chi, clo, cm1, cm2, cx;
    logic [79:0] son, sodd;
    logic [2:0]  up_r;
    logic [9:0]  prv_r;
    logic [15:0] run_r;
    logic [7:0]  dh_r;
    logic        ok_r;
    wire         live = up_r == 3'h4;
    // Duty pins unchanged over the last five samples, past the pin sync.
    wire         dsteady = dh_r == {4{duty_sel_hi_in, duty_sel_lo_in}};
    wire         last = duty_sel_hi_in ? cx[4] : duty_sel_lo_in ? cx[3] : cx[2];

    // Sorts every output into drive classes.
    always @* begin
        for (int k = 0; k < 80; k++) begin
            if (k < 5) begin
                chi[k] = common_out[2*k+:2] == 2'h3;
                clo[k] = common_out[2*k+:2] == 2'h0;
                cm1[k] = common_out[2*k+:2] == 2'h1;
                cm2[k] = common_out[2*k+:2] == 2'h2;
            end
            son[k]  = ~^segment_out[2*k+:2];
            sodd[k] = segment_out[2*k+1];
        end
        cx = chi | clo;
    end

    // Counts cycles since the commons last changed.
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            up_r  <= 3'h0;
            prv_r <= 10'h0;
            run_r <= 16'h0;
            dh_r  <= 8'h0;
            ok_r  <= 1'b0;
        end else begin
            up_r  <= live ? up_r : up_r + 3'h1;
            prv_r <= common_out;
            dh_r  <= {dh_r[5:0], duty_sel_hi_in, duty_sel_lo_in};
            run_r <= (common_out != prv_r) ? 16'h1 : run_r + 16'h1;
            ok_r  <= ~ext_osc_sel_in & (ok_r | (live & common_out != prv_r));
        end
    end

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    blank_off_a: assert property (!blank_n_in [*5] |-> son == 80'h0)
        else $error("segment driven on while blanked");
    one_act_a: assert property (live |-> $onehot(cx))
        else $error("active common count not one");
    hi_rest_a: assert property (live && chi != 5'h0 |-> (chi | cm2) == 5'h1f)
        else $error("idle common level wrong in high half");
    lo_rest_a: assert property (live && clo != 5'h0 |-> (clo | cm1) == 5'h1f)
        else $error("idle common level wrong in low half");
    pol_hi_a: assert property (live && chi != 5'h0 |-> sodd == 80'h0)
        else $error("segment level wrong in high half");
    pol_lo_a: assert property (live && clo != 5'h0 |-> &sodd)
        else $error("segment level wrong in low half");
    duty_wrap_a: assert property (dsteady && $fell(last) && live
        |-> cx[0])
        else $error("scan did not wrap after last common");
    half_len_a: assert property (ok_r && common_out != prv_r
        |-> run_r == 8 * OSC_DIV)
        else $error("half phase length wrong");

    cover property (chi[4]);
    cover property (!blank_n_in [*5]);
    cover property (ok_r && common_out != prv_r);
endmodule

bind lcd_segment_driver lcd_drv_chk #(.OSC_DIV(OSC_DIV)) i_chk (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .blank_n_in    (blank_n_in),
    .duty_sel_lo_in(duty_sel_lo_in),
    .duty_sel_hi_in(duty_sel_hi_in),
    .ext_osc_sel_in(ext_osc_sel_in),
    .common_out    (common_out),
    .segment_out   (segment_out)
);

/* File: tb/lcd_host_model.sv */
// ---------------------------------------------------------------
// Host serial port model
// ---------------------------------------------------------------
module lcd_host_model (
    input  wire  ref_clk_in,
    output logic ser_data_out,
    output logic shift_clk_out,
    output logic strobe_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle levels; the shift clock stands low between frames.
    initial begin
        ser_data_out  = 1'b0;
        shift_clk_out = 1'b0;
        strobe_out    = 1'b0;
    end

    // Shifts a frame, first bit first, at 800 ns, then strobes it.
    task automatic send(input logic [87:0] f);
        for (int i = 0; i < 88; i++) begin
            ser_data_out  <= f[i];
            shift_clk_out <= 1'b0;
            repeat (4) @(posedge ref_clk_in);
            shift_clk_out <= 1'b1;
            repeat (4) @(posedge ref_clk_in);
        end
        shift_clk_out <= 1'b0;
        ser_data_out  <= ~f[87];
        repeat (4) @(posedge ref_clk_in);
        strobe_out <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        strobe_out <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
    endtask
endmodule

/* File: tb/lcd_segment_driver_test.sv */
`include "lcd_drv_defs.vh"
// ---------------------------------------------------------------
// Segment driver bench
// ---------------------------------------------------------------
module lcd_segment_driver_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic         ref_clk_in, rst_in, blank_n_in, rc_a_in, load_ready_out;
    logic         duty_sel_lo_in, duty_sel_hi_in, ext_osc_sel_in;
    logic         ser_data_in, shift_clk_in, strobe_in, rc_run;
    logic [9:0]   common_out;
    logic [159:0] segment_out;
    logic [79:0]  pat [5];
    int           bad_count, checks_done;

    lcd_segment_driver #(.OSC_DIV(4)) i_dut (
        .ref_clk_in    (ref_clk_in),
        .rst_in        (rst_in),
        .ser_data_in   (ser_data_in),
        .shift_clk_in  (shift_clk_in),
        .strobe_in     (strobe_in),
        .blank_n_in    (blank_n_in),
        .duty_sel_lo_in(duty_sel_lo_in),
        .duty_sel_hi_in(duty_sel_hi_in),
        .ext_osc_sel_in(ext_osc_sel_in),
        .rc_a_in       (rc_a_in),
        .load_ready_out(load_ready_out),
        .common_out    (common_out),
        .segment_out   (segment_out)
    );
    lcd_host_model i_host (
        .ref_clk_in   (ref_clk_in),
        .ser_data_out (ser_data_in),
        .shift_clk_out(shift_clk_in),
        .strobe_out   (strobe_in)
    );

    // Clock and the 800 ns external oscillator.
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        forever begin
            repeat (4) @(posedge ref_clk_in);
            rc_a_in <= rc_run ? ~rc_a_in : rc_a_in;
        end
    end

    task automatic check(input logic [159:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Expected segment codes while the common is in its high half.
    function automatic logic [159:0] lv(input logic [79:0] p);
        for (int n = 0; n < 80; n++) begin
            lv[2*n+:2] = p[n] ? `LVL_LOW : `LVL_MID1;
        end
    endfunction

    // Waits for common k high, then compares the segments.
    task automatic show(input int k, input logic [79:0] p);
        int i;
        for (i = 0; i < 1000; i++) begin
            @(negedge ref_clk_in);
            if (common_out[2*k+:2] === `LVL_HIGH) break;
        end
        if (i == 1000) begin
            bad_count++;
            end_of_test;
        end else begin
            check(segment_out, lv(p & {80{blank_n_in}}));
        end
    endtask

    // One frame to all rows, shown through a blank cycle.
    task automatic s_load;
        i_host.send({3'h7, 5'h1f, {40{2'h1}}});
        for (int b = 0; b < 4; b++) begin
            @(posedge ref_clk_in);
            blank_n_in <= b[0];
            repeat (4) @(posedge ref_clk_in);
            for (int k = 0; k < 5; k++) show(k, {40{2'h1}});
        end
    endtask

    // A distinct pattern per row through one-hot selects.
    task automatic s_rows;
        for (int k = 0; k < 5; k++) begin
            pat[k] = {16{5'(k + 1)}};
            i_host.send({3'(k), 5'(1 << k), pat[k]});
        end
        for (int k = 0; k < 5; k++) show(k, pat[k]);
    endtask

    // Each duty reaches its last common and never the next one.
    task automatic s_duty;
        int c;
        for (int d = 0; d < 4; d++) begin
            @(posedge ref_clk_in);
            duty_sel_lo_in <= d[0];
            duty_sel_hi_in <= d[1];
            show(d > 1 ? 4 : d + 2, pat[d > 1 ? 4 : d + 2]);
            c = 0;
            repeat (400) begin
                @(negedge ref_clk_in);
                c += (common_out[2*(d > 1 ? 4 : d + 3)+:2] === `LVL_HIGH);
            end
            check(c != 0, d > 1);
        end
    endtask

    // Stalled oscillator fills the word buffer; the 17th is dropped.
    task automatic s_fifo;
        @(posedge ref_clk_in);
        ext_osc_sel_in <= 1'b1;
        check(load_ready_out, 1'b1);
        for (int i = 1; i < 18; i++) begin
            if (i == 17) check(load_ready_out, 1'b0);
            i_host.send({3'h0, 5'h01, 80'(i)});
        end
        rc_run = 1'b1;
        repeat (200) @(posedge ref_clk_in);
        show(0, 80'h10);
    endtask

    initial begin
        rst_in         = 1'b1;
        blank_n_in     = 1'b0;
        duty_sel_lo_in = 1'b0;
        duty_sel_hi_in = 1'b1;
        ext_osc_sel_in = 1'b0;
        rc_a_in        = 1'b0;
        rc_run         = 1'b0;
        repeat (8) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        s_load;
        s_rows;
        s_duty;
        s_fifo;
        end_of_test;
    end
endmodule
